// File: design/cxf_params.svh
// Purpose: constants for the exception frame and fault detect block
// Assumes: included by bare name
// Notes:   offsets, codes, vectors and opword fields
`ifndef CXF_PARAMS_SVH
`define CXF_PARAMS_SVH

// register word offsets (byte addresses)
`define CXF_OFF_CTRL     8'h00
`define CXF_OFF_SSP      8'h04
`define CXF_OFF_VBR      8'h08
`define CXF_OFF_FVW      8'h0c
`define CXF_OFF_FPC      8'h10
`define CXF_OFF_SRW      8'h14
`define CXF_OFF_HADDR    8'h18
`define CXF_OFF_STAT     8'h1c

// control register bits
`define CXF_CTRL_MMU_EN  0
`define CXF_CTRL_UHE     1
`define CXF_CTRL_DEBUG   2

// status word fields
`define CXF_SR_TRACE     15
`define CXF_SR_SUPER     13

// format field codes
`define CXF_FMT_BASE     4'h4

// fault status codes
`define CXF_FS_NONE      4'h0
`define CXF_FS_IRQ_DBG   4'h2
`define CXF_FS_IFETCH    4'h4
`define CXF_FS_ITLB_OP   4'h5
`define CXF_FS_ITLB_EXT  4'h6
`define CXF_FS_DBG_IF    4'h7
`define CXF_FS_WR_ERR    4'h8
`define CXF_FS_WR_PROT   4'h9
`define CXF_FS_WR_TLB    4'ha
`define CXF_FS_RD_ERR    4'hc
`define CXF_FS_RD_PROT   4'hd
`define CXF_FS_RD_TLB    4'he
`define CXF_FS_DBG_DATA  4'hf

// vector numbers
`define CXF_VEC_ACCESS   8'h02
`define CXF_VEC_ADDRESS  8'h03
`define CXF_VEC_ILLEGAL  8'h04
`define CXF_VEC_DIVZERO  8'h05
`define CXF_VEC_PRIV     8'h08
`define CXF_VEC_TRACE    8'h09
`define CXF_VEC_LINE_A   8'h0a
`define CXF_VEC_LINE_F   8'h0b

// opword fields
`define CXF_LINE_A       4'ha
`define CXF_LINE_F       4'hf
`define CXF_EXT_FULL     8

`endif

// File: design/cxf_pkg.sv
// Purpose: types for the exception frame and fault detect block
// Assumes: nothing
// Notes:   no imports anywhere; use cxf_pkg::name
package cxf_pkg;

  typedef enum logic [1:0] {
    CXF_IDLE  = 2'b00,
    CXF_FRAME = 2'b01,
    CXF_FETCH = 2'b10,
    CXF_HALT  = 2'b11
  } cxf_state_e;

  // one fault report per cycle from pipelines, bus and mmu
  typedef struct packed {
    logic       fetch_err;     // bus error on fetch, word needed
    logic       fetch_tlb_op;  // translation miss on opword
    logic       fetch_tlb_ext; // translation miss on extension
    logic       fetch_flushed; // needed word discarded by flow change
    logic       rd_err;        // operand read error ack
    logic       rd_prot;       // protected read or rmw
    logic       rd_tlb;        // read translation miss
    logic       wr_err;        // operand write error ack
    logic       wr_prot;       // write to protected space
    logic       wr_tlb;        // write translation miss
  } cxf_fault_s;

  // decoded instruction going to execute
  typedef struct packed {
    logic        valid;       // instruction issues this cycle
    logic [15:0] opword;      // first word
    logic [15:0] ext1;        // first extension word
    logic        indexed;     // uses indexed addressing
    logic        illegal;     // opword not defined
    logic        supv_only;   // supervisor-only instruction
    logic        is_halt;     // halt instruction
    logic        is_stop;     // stop instruction
    logic [15:0] stop_imm;    // stop immediate
    logic        is_div;      // divide instruction
    logic [31:0] divisor;     // divisor operand
    logic        flow;        // change of flow
    logic [31:0] target;      // flow target
    logic        is_call;     // subroutine call
    logic        is_ret;      // subroutine return
    logic [31:0] pc;          // address of this instruction
    logic [31:0] next_pc;     // address of the following one
  } cxf_inst_s;

  typedef struct packed {
    logic [3:0]  format;
    logic [3:0]  fs_hi;
    logic [7:0]  vector;
    logic [3:0]  fs_lo;
  } cxf_fvw_s;

endpackage

// File: design/cxf_unit.sv
// Purpose: exception detect, frame build and vector fetch for the core
// Assumes: wishbone classic slave; one core clock; sync reset
// Notes:   frame words are held for the stacking logic to write
`include "cxf_params.svh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module cxf_unit (
  input  wire logic               core_clk,       // core clock
  input  wire logic               srst,           // sync reset, high
  input  wire logic [7:0]         wb_adr_i,       // bus byte address
  input  wire logic [31:0]        wb_dat_i,       // bus write data
  output logic      [31:0]        wb_dat_o,       // bus read data
  input  wire logic               wb_we_i,        // write enable
  input  wire logic [3:0]         wb_sel_i,       // byte selects
  input  wire logic               wb_cyc_i,       // cycle
  input  wire logic               wb_stb_i,       // strobe
  output logic                    wb_ack_o,       // acknowledge
  output logic                    wb_err_o,       // unmapped address
  input  wire cxf_pkg::cxf_inst_s inst_i,         // issuing instruction
  input  wire cxf_pkg::cxf_fault_s fault_i,       // fault reports
  input  wire logic [15:0]        status_word_i,  // processor_status_word
  input  wire logic               irq_i,          // interrupt taken
  input  wire logic [7:0]         irq_vec_i,      // vector from controller
  input  wire logic               vfetch_ack_i,   // vector fetch started
  output logic                    abort_o,        // abort and restore regs
  output logic                    push_ret_o,     // push return first
  output logic                    keep_ret_o,     // frame above return
  output logic                    exc_busy_o,     // exception in progress
  output logic [31:0]             frame_w0_o,     // format/vector + status
  output logic [31:0]             frame_pc_o,     // stacked pc
  output logic                    vfetch_req_o,   // vector fetch request
  output logic [31:0]             vfetch_adr_o,   // vector address
  output logic                    halted_o        // fault on fault
);

  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic [31:0] ctrl_q, ssp_q, vbr_q;
  logic [31:0] last_w0_q, last_pc_q;
  logic        hit, wr;
  logic [31:0] rd_d;
  cxf_pkg::cxf_state_e state_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0;
    case (wb_adr_i)
      `CXF_OFF_CTRL:  rd_d = ctrl_q;
      `CXF_OFF_SSP:   rd_d = ssp_q;
      `CXF_OFF_VBR:   rd_d = vbr_q;
      `CXF_OFF_FVW:   rd_d = last_w0_q;
      `CXF_OFF_FPC:   rd_d = last_pc_q;
      `CXF_OFF_SRW:   rd_d = {16'h0, status_word_i};
      `CXF_OFF_HADDR: rd_d = vfetch_adr_o;
      `CXF_OFF_STAT:  rd_d = {29'h0, halted_o, state_q};
      default:        hit  = 1'b0;
    endcase
  end

  // one wait state: ack the cycle after strobe, then drop
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && hit && !wb_ack_o;
      wb_err_o <= wb_cyc_i && wb_stb_i && !hit && !wb_err_o;
      wb_dat_o <= rd_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= 32'h0;
      ssp_q  <= 32'h0;
      vbr_q  <= 32'h0;
    end else if (wr && hit) begin
      if (wb_adr_i == `CXF_OFF_CTRL) ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `CXF_OFF_SSP)  ssp_q  <= merge(ssp_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `CXF_OFF_VBR)  vbr_q  <= merge(vbr_q, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detection
  logic mmu_en, user_halt_permit, debug_mode, user_mode, trace_flag;
  assign mmu_en           = ctrl_q[`CXF_CTRL_MMU_EN];
  assign user_halt_permit = ctrl_q[`CXF_CTRL_UHE];
  assign debug_mode       = ctrl_q[`CXF_CTRL_DEBUG];
  assign user_mode        = !status_word_i[`CXF_SR_SUPER];
  assign trace_flag       = status_word_i[`CXF_SR_TRACE];

  logic [3:0] op_line;
  logic [5:0] op_mode, op_ea;
  assign op_line = inst_i.opword[15:12];
  assign op_mode = inst_i.opword[11:6];
  assign op_ea   = inst_i.opword[5:0];

  logic fetch_fault, ifetch_any, rd_any, wr_any, acc_err, addr_err;
  logic illegal, line_a, line_f, div_zero, priv, trace_now;
  logic stop_trace_q;

  // only faults on words issued, not flushed ones
  assign ifetch_any = inst_i.valid && !fault_i.fetch_flushed &&
                      (fault_i.fetch_err || fault_i.fetch_tlb_op ||
                       fault_i.fetch_tlb_ext);
  // mmu off: all fetch and read faults and write translation faults suppressed
  // error ack and mmu faults raise access error
  assign fetch_fault = mmu_en && ifetch_any;
  assign rd_any = mmu_en &&
                  (fault_i.rd_err || fault_i.rd_prot || fault_i.rd_tlb);
  assign wr_any = fault_i.wr_err || fault_i.wr_prot ||
                  (mmu_en && fault_i.wr_tlb);
  assign acc_err = fetch_fault || rd_any || wr_any;

  // odd target; word index, scale 8, full format
  // ext word used only for the index form, never for illegality
  assign addr_err = inst_i.valid &&
                    ((inst_i.flow && inst_i.target[0]) ||
                     (inst_i.indexed && (!inst_i.ext1[11] ||
                      inst_i.ext1[10:9] == 2'b11 ||
                      inst_i.ext1[`CXF_EXT_FULL])));

  assign line_a  = inst_i.valid && inst_i.illegal && op_line == `CXF_LINE_A;
  assign line_f  = inst_i.valid && inst_i.illegal && op_line == `CXF_LINE_F;
  assign illegal = inst_i.valid && inst_i.illegal && !line_a && !line_f;
  assign div_zero = inst_i.valid && inst_i.is_div && inst_i.divisor == 32'h0;
  assign priv = inst_i.valid && inst_i.supv_only && user_mode &&
                !(inst_i.is_halt && user_halt_permit);
  // trace on completion, stop excluded unless it sets T
  assign trace_now = inst_i.valid &&
                     ((trace_flag && !inst_i.is_stop) ||
                      (inst_i.is_stop && inst_i.stop_imm[`CXF_SR_TRACE]));

  ////////////////////////////////////////////////////////////////////////
  // selection
  logic        take;
  logic [7:0]  vec_d;
  logic [3:0]  fs_d;
  logic [31:0] pc_d;
  logic [15:0] sr_d;

  always_comb begin
    take  = 1'b1;
    vec_d = 8'h00;
    fs_d  = `CXF_FS_NONE;
    pc_d  = inst_i.pc;
    sr_d  = status_word_i;
    if (acc_err) begin
      vec_d = `CXF_VEC_ACCESS;
      if (fetch_fault) begin
        if (debug_mode)                 fs_d = `CXF_FS_DBG_IF;
        else if (fault_i.fetch_tlb_op)  fs_d = `CXF_FS_ITLB_OP;
        else if (fault_i.fetch_tlb_ext) fs_d = `CXF_FS_ITLB_EXT;
        else                            fs_d = `CXF_FS_IFETCH;
      end else if (debug_mode) begin
        fs_d = `CXF_FS_DBG_DATA;
      end else if (rd_any) begin
        if (fault_i.rd_tlb)       fs_d = `CXF_FS_RD_TLB;
        else if (fault_i.rd_prot) fs_d = `CXF_FS_RD_PROT;
        else                      fs_d = `CXF_FS_RD_ERR;
      end else begin
        if (fault_i.wr_tlb)       fs_d = `CXF_FS_WR_TLB;
        else if (fault_i.wr_prot) fs_d = `CXF_FS_WR_PROT;
        else                      fs_d = `CXF_FS_WR_ERR;
      end
    end else if (addr_err) begin
      // address errors keep a zero code here
      vec_d = `CXF_VEC_ADDRESS;
    end else if (illegal) begin
      vec_d = `CXF_VEC_ILLEGAL;
    end else if (line_a) begin
      vec_d = `CXF_VEC_LINE_A;
    end else if (line_f) begin
      vec_d = `CXF_VEC_LINE_F;
    end else if (priv) begin
      vec_d = `CXF_VEC_PRIV;
    end else if (div_zero) begin
      vec_d = `CXF_VEC_DIVZERO;
    // armed flag waits for the stop to reissue, never traps an empty slot
    end else if (trace_now ||
                 (stop_trace_q && inst_i.valid && inst_i.is_stop)) begin
      vec_d = `CXF_VEC_TRACE;
      // before a stop the pc points at the stop itself
      if (inst_i.is_stop && trace_flag && !stop_trace_q) begin
        pc_d = inst_i.pc;
      end else begin
        pc_d = inst_i.next_pc;
        // stacked status is the newly loaded one
        if (inst_i.is_stop) sr_d = inst_i.stop_imm;
      end
    end else if (irq_i) begin
      vec_d = irq_vec_i;
      pc_d  = inst_i.next_pc;
      if (debug_mode) fs_d = `CXF_FS_IRQ_DBG;
    end else begin
      take = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence
  // traced stop: the stop issue traps with pc at stop, then reissues
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stop_trace_q <= 1'b0;
    end else if (state_q == cxf_pkg::CXF_IDLE && take) begin
      // first trap on the stop arms the second
      stop_trace_q <= inst_i.is_stop && trace_flag && !stop_trace_q &&
                      vec_d == `CXF_VEC_TRACE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= cxf_pkg::CXF_IDLE;
    end else begin
      case (state_q)
        cxf_pkg::CXF_IDLE: begin
          if (take) state_q <= cxf_pkg::CXF_FRAME;
        end
        cxf_pkg::CXF_FRAME: begin
          // a fault during exception processing halts the core
          if (acc_err) state_q <= cxf_pkg::CXF_HALT;
          else         state_q <= cxf_pkg::CXF_FETCH;
        end
        cxf_pkg::CXF_FETCH: begin
          if (acc_err)           state_q <= cxf_pkg::CXF_HALT;
          else if (vfetch_ack_i) state_q <= cxf_pkg::CXF_IDLE;
        end
        cxf_pkg::CXF_HALT: state_q <= cxf_pkg::CXF_HALT;
        default:           state_q <= cxf_pkg::CXF_IDLE;
      endcase
    end
  end

  cxf_pkg::cxf_fvw_s fvw;
  always_comb begin
    // format from original ssp low bits
    fvw.format = `CXF_FMT_BASE | {2'b00, ssp_q[1:0]};
    fvw.fs_hi  = fs_d;
    fvw.vector = vec_d;
    fvw.fs_lo  = `CXF_FS_NONE;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_w0_o <= 32'h0;
      frame_pc_o <= 32'h0;
      last_w0_q  <= 32'h0;
      last_pc_q  <= 32'h0;
      abort_o    <= 1'b0;
      push_ret_o <= 1'b0;
      keep_ret_o <= 1'b0;
    end else if (state_q == cxf_pkg::CXF_IDLE && take) begin
      // fs bits sit at 11:10 and 1:0 of the format/vector word
      frame_w0_o <= {fvw.format, fvw.fs_hi[3:2], fvw.vector, fvw.fs_hi[1:0],
                     sr_d};
      frame_pc_o <= pc_d;
      last_w0_q  <= {fvw.format, fvw.fs_hi[3:2], fvw.vector, fvw.fs_hi[1:0],
                     sr_d};
      last_pc_q  <= pc_d;
      // abort faulting instruction, restore registers
      // faults only; trace and interrupts let the instruction complete
      abort_o    <= acc_err || addr_err || illegal || line_a || line_f ||
                    priv || div_zero;
      // call pushes return, return keeps its value
      push_ret_o <= addr_err && inst_i.is_call;
      keep_ret_o <= addr_err && inst_i.is_ret;
    end else begin
      abort_o    <= 1'b0;
      push_ret_o <= 1'b0;
      keep_ret_o <= 1'b0;
    end
  end

  // handler vector at base plus four times number
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vfetch_req_o <= 1'b0;
      vfetch_adr_o <= 32'h0;
      exc_busy_o   <= 1'b0;
      halted_o     <= 1'b0;
    end else begin
      vfetch_req_o <= state_q == cxf_pkg::CXF_FRAME ||
                      (state_q == cxf_pkg::CXF_FETCH && !vfetch_ack_i);
      if (state_q == cxf_pkg::CXF_FRAME) begin
        vfetch_adr_o <= vbr_q + {22'h0, frame_w0_o[25:18], 2'b00};
      end
      exc_busy_o <= (state_q == cxf_pkg::CXF_IDLE && take) ||
                    state_q == cxf_pkg::CXF_FRAME ||
                    (state_q == cxf_pkg::CXF_FETCH && !vfetch_ack_i);
      halted_o   <= state_q == cxf_pkg::CXF_HALT;
    end
  end

endmodule

`default_nettype wire

// File: testbench/cxf_unit_monitor.sv
// Purpose: port checks for cxf_unit
// Assumes: vector base written 1 MB aligned
// Notes:   bound into every cxf_unit
`timescale 1ns/100ps
`default_nettype none
module cxf_unit_monitor (
  input wire logic                core_clk,      // clock
  input wire logic                srst,          // reset
  input wire cxf_pkg::cxf_inst_s  inst_i,        // issuing op
  input wire cxf_pkg::cxf_fault_s fault_i,       // faults
  input wire logic [15:0]         status_word_i, // status
  input wire logic                irq_i,         // irq
  input wire logic [7:0]          irq_vec_i,     // irq vector
  input wire logic                vfetch_ack_i,  // fetch ack
  input wire logic                abort_o,       // abort
  input wire logic                push_ret_o,    // push first
  input wire logic                keep_ret_o,    // keep return
  input wire logic                exc_busy_o,    // busy
  input wire logic [31:0]         frame_w0_o,    // frame word
  input wire logic                vfetch_req_o,  // fetch req
  input wire logic [31:0]         vfetch_adr_o,  // fetch addr
  input wire logic                halted_o       // halted
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic       idle;
  logic       op;
  logic [7:0] vec;
  logic [3:0] fs;
  assign idle = !exc_busy_o && !halted_o;
  assign op   = idle && inst_i.valid && fault_i == '0;
  assign vec  = frame_w0_o[25:18];
  assign fs   = {frame_w0_o[27:26], frame_w0_o[17:16]};
////////////////////////////////////////
  fmt_range_a: assert property (
    $rose(exc_busy_o) |-> frame_w0_o[31:30] == 2'b01) else $error("format");
  fs_zero_a: assert property (
    $rose(exc_busy_o) && vec inside {[8'h04:8'h0b]} |-> fs == 4'h0)
    else $error("fault status not zero");
  irq_vec_a: assert property (
    idle && irq_i && !inst_i.valid && fault_i == '0
    |=> exc_busy_o && vec == $past(irq_vec_i)) else $error("irq vector");
  rd_abort_a: assert property (
    $rose(exc_busy_o) && fs == 4'hc |-> abort_o) else $error("no abort");
  odd_target_a: assert property (
    op && inst_i.flow && inst_i.target[0] |=> exc_busy_o && vec == 8'h03)
    else $error("odd target");
  call_push_a: assert property (
    op && inst_i.flow && inst_i.target[0] && inst_i.is_call |=> push_ret_o)
    else $error("no push");
  ret_keep_a: assert property (
    op && inst_i.flow && inst_i.target[0] && inst_i.is_ret |=> keep_ret_o)
    else $error("no keep");
  div_zero_a: assert property (
    op && inst_i.is_div && inst_i.divisor == 32'h0 |=> exc_busy_o)
    else $error("zero divide missed");
  trace_take_a: assert property (
    op && status_word_i[15] && !inst_i.is_stop |=> exc_busy_o)
    else $error("trace missed");
  vec_fetch_a: assert property (
    $rose(exc_busy_o) |=> vfetch_req_o && vfetch_adr_o[9:2] == vec)
    else $error("vector fetch");
  req_hold_a: assert property (
    vfetch_req_o && !vfetch_ack_i |=> vfetch_req_o || halted_o)
    else $error("req drop");
  one_exc_a: assert property (
    exc_busy_o && $past(exc_busy_o) |-> $stable(frame_w0_o))
    else $error("frame changed while busy");
  cover property ($rose(exc_busy_o));
  cover property (abort_o);
  cover property (vfetch_req_o && !vfetch_ack_i ##1 vfetch_req_o);
  cover property ($rose(halted_o));
endmodule
bind cxf_unit cxf_unit_monitor u_mon (.core_clk, .srst, .inst_i, .fault_i,
  .status_word_i, .irq_i, .irq_vec_i, .vfetch_ack_i, .abort_o, .push_ret_o,
  .keep_ret_o, .exc_busy_o, .frame_w0_o, .vfetch_req_o, .vfetch_adr_o,
  .halted_o);
`default_nettype wire

// File: testbench/cxf_far_model.sv
// Purpose: memory side answering vector fetches
// Assumes: req holds until ack seen
// Notes:   slow adds three cycles of wait
`timescale 1ns/100ps
`default_nettype none
module cxf_far_model (
  input wire logic core_clk, // clock
  input wire logic srst,     // reset
  input wire logic req,      // fetch request
  input wire logic slow,     // stretch answer
  output var logic ack       // fetch started
);
  logic [1:0] cnt_q;
  // no second pulse while req falls
  always_ff @(posedge core_clk) begin
    if (srst || !req || ack) begin
      ack   <= 1'b0;
      cnt_q <= 2'h0;
    end else if (!slow || cnt_q == 2'h3) begin
      ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/cxf_unit_tb.sv
// Purpose: self-checking bench for cxf_unit
// Assumes: one-cycle wishbone answer
// Notes:   rows hold ordinary faults
`include "cxf_params.svh"
`timescale 1ns/100ps
`default_nettype none
module cxf_unit_tb;
  typedef struct packed {
    cxf_pkg::cxf_inst_s  i;
    cxf_pkg::cxf_fault_s f;
    logic [15:0] sr;
    logic        q;
    logic [7:0]  v;
    logic [3:0]  fs;
    logic [1:0]  pm;
    logic        cf;
  } cxf_row_s;
  localparam logic [31:0] vbr = 32'h0010_0000;
  localparam logic [15:0] ssr = 16'h2000;
  logic core_clk, srst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic [7:0] wb_adr_i, irq_vec_i;
  logic [31:0] wb_dat_i, wb_dat_o, frame_w0_o, frame_pc_o, vfetch_adr_o, q;
  logic [3:0] wb_sel_i;
  logic [15:0] status_word_i;
  logic irq_i, vfetch_ack_i, exc_busy_o, vfetch_req_o, halted_o, slow, e;
  cxf_pkg::cxf_inst_s  inst_i, b, t;
  cxf_pkg::cxf_fault_s fault_i;
  int mismatches, comparisons, tn;
  cxf_row_s rows[$];
  logic [3:0] fsv [10] = '{4'h4, 4'h5, 4'h6, 4'h0, 4'hc, 4'hd, 4'he,
                           4'h8, 4'h9, 4'ha};
  cxf_unit u_dut (.core_clk, .srst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
    .inst_i, .fault_i, .status_word_i, .irq_i, .irq_vec_i, .vfetch_ack_i,
    .abort_o(), .push_ret_o(), .keep_ret_o(), .exc_busy_o, .frame_w0_o,
    .frame_pc_o, .vfetch_req_o, .vfetch_adr_o, .halted_o);
  cxf_far_model u_far (.core_clk, .srst, .req(vfetch_req_o), .slow,
    .ack(vfetch_ack_i));
////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, 4'hf};
    // ack or err ends the wait; only the watchdog ends one with no answer
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic cxf_row_s mk(cxf_pkg::cxf_inst_s i, logic [9:0] f,
      logic [15:0] sr, logic q, logic [7:0] v, logic [3:0] fs,
      logic [1:0] pm, logic cf);
    mk = '{i, cxf_pkg::cxf_fault_s'(f), sr, q, v, fs, pm, cf};
  endfunction
  task automatic fire(cxf_row_s r);
    logic [31:0] w;
    logic [15:0] es;
    int n;
    es = (r.i.is_stop && r.pm == 2'h1) ? r.i.stop_imm : r.sr;
    @(posedge core_clk);
    {inst_i, fault_i, status_word_i, irq_i} <= {r.i, r.f, r.sr, r.q};
    @(posedge core_clk);
    {inst_i, fault_i, irq_i} <= '0;
    @(posedge core_clk);
    w = frame_w0_o;
    if (r.v == 8'h00) chk("idle", 32'(exc_busy_o), 32'h0);
    else begin
      chk("vector", 32'(w[25:18]), 32'(r.v));
      chk("format", 32'(w[31:28]), 32'h6);
      chk("sr", 32'(w[15:0]), 32'(es));
      if (r.cf) chk("fs", 32'({w[27:26], w[17:16]}), 32'(r.fs));
      if (r.pm != 2'h2)
        chk("pc", frame_pc_o, r.pm[0] ? r.i.next_pc : r.i.pc);
      @(posedge core_clk);
      chk("vadr", vfetch_adr_o, vbr + {22'h0, r.v, 2'b00});
      n = 0;
      while (exc_busy_o !== 1'b0 && n < 40) begin
        @(posedge core_clk);
        n++;
      end
      chk("done", 32'(exc_busy_o), 32'h0);
    end
    $display("case %0d done", tn++);
  endtask
////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    {srst, wb_cyc_i, wb_stb_i, wb_we_i, irq_i, slow} = 6'h20;
    {wb_adr_i, wb_dat_i, wb_sel_i, inst_i, fault_i} = '0;
    {status_word_i, irq_vec_i} = {ssr, 8'h40};
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk("rst", {frame_w0_o[30:0], exc_busy_o}, 32'h0);
    wb(`CXF_OFF_SSP, 1'b1, 32'h8002);
    wb(`CXF_OFF_VBR, 1'b1, vbr);
    wb(`CXF_OFF_CTRL, 1'b1, 32'h1);
    wb(`CXF_OFF_VBR, 1'b0, 32'h0);
    chk("vbr", q, vbr);
    wb(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'(e), 32'h1);
    b = '0;
    {b.valid, b.opword, b.pc, b.next_pc} = {1'b1, 16'h4e71, 32'h1000, 32'h1002};
    t = b; {t.is_div, t.divisor} = 33'h1_0000_0000;
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_DIVZERO, 0, 0, 1));
    rows.push_back(mk(t, 0, 16'ha000, 0, `CXF_VEC_DIVZERO, 0, 0, 1));
    t = b; {t.illegal, t.opword} = {1'b1, 16'h4afc};
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_ILLEGAL, 0, 0, 1));
    t.opword = 16'ha000;
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_LINE_A, 0, 0, 1));
    t.opword = 16'hf000;
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_LINE_F, 0, 0, 1));
    t = b; t.supv_only = 1'b1;
    rows.push_back(mk(t, 0, 16'h0, 0, `CXF_VEC_PRIV, 0, 0, 1));
    t.is_halt = 1'b1;
    rows.push_back(mk(t, 0, 16'h0, 0, `CXF_VEC_PRIV, 0, 0, 1));
    t = b; {t.flow, t.target} = {1'b1, 32'h1001};
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_ADDRESS, 0, 0, 0));
    t.is_call = 1'b1;
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_ADDRESS, 0, 0, 0));
    {t.is_call, t.is_ret} = 2'b01;
    rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_ADDRESS, 0, 0, 0));
    t = b; t.indexed = 1'b1;
    for (int k = 0; k < 3; k++) begin
      t.ext1 = k == 0 ? 16'h0000 : (k == 1 ? 16'h0e00 : 16'h0900);
      rows.push_back(mk(t, 0, ssr, 0, `CXF_VEC_ADDRESS, 0, 0, 0));
    end
    rows.push_back(mk(b, 0, 16'ha000, 0, `CXF_VEC_TRACE, 0, 1, 1));
    for (int k = 0; k < 10; k++)
      if (k != 3) rows.push_back(mk(b, 10'h200 >> k, ssr, 0,
        `CXF_VEC_ACCESS, fsv[k], 0, 1));
    foreach (rows[k]) begin
      slow <= 1'(k);
      fire(rows[k]);
    end
    fire(mk(b, 10'h240, ssr, 0, 0, 0, 0, 0));
    t = b; {t.is_div, t.divisor} = 33'h1_0000_0003;
    fire(mk(t, 0, ssr, 0, 0, 0, 0, 0));
    wb(`CXF_OFF_CTRL, 1'b1, 32'h0);
    fire(mk(b, 10'h020, ssr, 0, 0, 0, 0, 0));
    fire(mk(b, 10'h002, ssr, 0, `CXF_VEC_ACCESS, 4'h9, 0, 1));
    wb(`CXF_OFF_CTRL, 1'b1, 32'h3);
    t = b; {t.is_halt, t.supv_only} = 2'b11;
    fire(mk(t, 0, 16'h0, 0, 0, 0, 0, 0));
    fire(mk('0, 0, ssr, 1, 8'h40, 0, 2, 1));
    wb(`CXF_OFF_CTRL, 1'b1, 32'h5);
    fire(mk('0, 0, ssr, 1, 8'h40, 4'h2, 2, 1));
    fire(mk(b, 10'h200, ssr, 0, `CXF_VEC_ACCESS, 4'h7, 0, 1));
    fire(mk(b, 10'h020, ssr, 0, `CXF_VEC_ACCESS, 4'hf, 0, 1));
    wb(`CXF_OFF_CTRL, 1'b1, 32'h1);
    t = b; {t.is_stop, t.stop_imm} = {1'b1, 16'ha700};
    fire(mk(t, 0, ssr, 0, `CXF_VEC_TRACE, 0, 1, 1));
    fire(mk(t, 0, 16'ha000, 0, `CXF_VEC_TRACE, 0, 0, 1));
    fire(mk(t, 0, 16'ha000, 0, `CXF_VEC_TRACE, 0, 1, 1));
    // fault held into frame build halts until reset
    @(posedge core_clk);
    fault_i <= cxf_pkg::cxf_fault_s'(10'h002);
    repeat (4) @(posedge core_clk);
    chk("halt", 32'(halted_o), 32'h1);
    fault_i <= '0;
    srst    <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk("rst2", {30'h0, halted_o, exc_busy_o}, 32'h0);
    wb(`CXF_OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", q, 32'h0);
    $display("case %0d done", tn++);
    end_sim();
  end
endmodule
`default_nettype wire
